/* File: ptc_map.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH
// ==========================================================================
// Register offsets
`define PTC_OFS_CTRL      12'h600
`define PTC_OFS_NSL       12'h604
`define PTC_OFS_NSH       12'h606
`define PTC_OFS_SL        12'h608
`define PTC_OFS_SH        12'h60A
`define PTC_OFS_PHASE     12'h60C
`define PTC_OFS_RATEL     12'h610
`define PTC_OFS_RATEH     12'h612
`define PTC_OFS_DURL      12'h614
`define PTC_OFS_DURH      12'h616
// ==========================================================================
// Field positions
`define PTC_BIT_RESET     0
`define PTC_BIT_RUN       1
`define PTC_BIT_CONT      2
`define PTC_BIT_LOAD      3
`define PTC_BIT_READ      4
`define PTC_BIT_STEPDIR   5
`define PTC_BIT_STEP      6
`define PTC_BIT_TEMP      14
`define PTC_BIT_RATEDIR   15
// ==========================================================================
// Reset values and timing
`define PTC_RUN_RESET     1'b1
`define PTC_WORD_RESET    16'h0000
`define PTC_CLK_PERIOD_NS 20
`define PTC_REF_PERIOD_NS 40
`define PTC_REF_DIV       (`PTC_REF_PERIOD_NS / `PTC_CLK_PERIOD_NS)
`define PTC_NS_PER_SEC    30'h3B9ACA00
`endif

/* File: ptc_pkg.sv */
// Types shared by the time clock core.
package ptc_pkg;
    typedef logic [29:0] ptc_ns_type;
    typedef logic [31:0] ptc_sec_type;
    typedef enum logic [2:0] {
        PTC_ACT_NONE,
        PTC_ACT_RESET,
        PTC_ACT_LOAD,
        PTC_ACT_STEP,
        PTC_ACT_TICK
    } ptc_act_type;
endpackage : ptc_pkg

/* File: ptc_ref_tick.sv */
// Reference period tick generator for the time clock.
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptc_ref_tick (
    input  wire logic clk,
    input  wire logic reset_n,
    output logic      tick_q
);
    logic [3:0] cnt_q;
    wire        last = (cnt_q == 4'(`PTC_REF_DIV - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q  <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= last ? 4'h0 : cnt_q + 4'h1;
            tick_q <= last;
        end
    end
endmodule : ptc_ref_tick

/* File: ptc_core.sv */
// Time clock core with its host register file.
// Behaviour
// - Continuous enable applies rate every reference cycle; direction 0 adds.
// - Run enable resets to 1; clear freezes the time clock.
// - Writing 1 to reset request zeroes the time; the bit self-clears.
// - Nanoseconds are 30 bits split over low word and high bits 13..0.
// - Nanosecond high bits 15..14 are plain storage outside the counter.
// - Seconds are 32 bits split into low and high words.
// - Time advances once per 40 ns; sub-phase shows the 8 ns slice.
// - Sub-phase codes 000 to 100 mean 0 to 32 ns.
// - Any host write to a time word forces sub-phase to zero.
// - Rate is 30 bits in 2^-32 ns units from two words.
// - Each reference cycle adds the period plus or minus the rate.
// - A zero rate disables continuous and temporary adjustment.
// - Read snapshot copies live time into the time registers, self-clears.
// - Load copies the time registers into the live clock, self-clears.
// - Step adds or subtracts the nanosecond registers, by step direction.
// - Temporary enable applies rate for a counted duration, then clears.
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptc_core
    import ptc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [11:0] host_addr,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata_q
);
    // ======================================================================
    // Storage
    logic        run_q, cont_q, step_dir_q, rate_dir_q, temp_q;
    logic        req_rst_q, req_load_q, req_read_q, req_step_q;
    logic [15:0] nsl_q, nsh_q, sl_q, sh_q, rate_l_q, dur_l_q, dur_h_q;
    logic [13:0] rate_h_q;
    logic [2:0]  phase_q, rtc_phase_q, rtc_phase_d;
    logic [31:0] dur_cnt_q, rtc_frac_q, rtc_frac_d;
    ptc_ns_type  rtc_ns_q, rtc_ns_d;
    ptc_sec_type rtc_sec_q, rtc_sec_d;
    ptc_act_type act;
    logic        tick;
    logic [15:0] rd_mux;

    ptc_ref_tick u_tick (
        .clk     (clk),
        .reset_n (reset_n),
        .tick_q  (tick)
    );

    // ======================================================================
    // Address decode
    wire wr_ctrl  = host_wr && (host_addr == `PTC_OFS_CTRL);
    wire wr_nsl   = host_wr && (host_addr == `PTC_OFS_NSL);
    wire wr_nsh   = host_wr && (host_addr == `PTC_OFS_NSH);
    wire wr_sl    = host_wr && (host_addr == `PTC_OFS_SL);
    wire wr_sh    = host_wr && (host_addr == `PTC_OFS_SH);
    wire wr_phase = host_wr && (host_addr == `PTC_OFS_PHASE);
    wire wr_ratel = host_wr && (host_addr == `PTC_OFS_RATEL);
    wire wr_rateh = host_wr && (host_addr == `PTC_OFS_RATEH);
    wire wr_durl  = host_wr && (host_addr == `PTC_OFS_DURL);
    wire wr_durh  = host_wr && (host_addr == `PTC_OFS_DURH);
    wire wr_time  = wr_nsl || wr_nsh || wr_sl || wr_sh;

    // ======================================================================
    // Time arithmetic
    wire [31:0] rate_val = {2'b00, rate_h_q, rate_l_q};
    wire        rate_on  = (cont_q || temp_q) && (rate_val != 32'h0);
    wire [29:0] step_val = {nsh_q[13:0], nsl_q};
    wire [61:0] cur_fix  = {rtc_ns_q, rtc_frac_q};
    wire [61:0] base_fix = cur_fix + {30'(`PTC_REF_PERIOD_NS), 32'h0};
    wire [61:0] rate_fix = {30'h0, rate_val};
    // Direction 0 speeds the clock up, direction 1 slows it down.
    wire [61:0] adj_fix  = !rate_on ? base_fix :
                           (rate_dir_q ? base_fix - rate_fix
                                       : base_fix + rate_fix);
    wire [29:0] adj_ns   = adj_fix[61:32];
    wire        tick_wr  = (adj_ns >= `PTC_NS_PER_SEC);
    wire [30:0] step_sum = {1'b0, rtc_ns_q} + {1'b0, step_val};
    wire        step_wr  = (step_sum >= {1'b0, `PTC_NS_PER_SEC});
    wire        step_un  = (rtc_ns_q < step_val);
    wire        dur_done = (dur_cnt_q == 32'h0) ||
                           ((act == PTC_ACT_TICK) && (dur_cnt_q == 32'h1));

    // A step or load in a tick cycle takes the place of that tick.
    always_comb begin
        if (req_rst_q) begin
            act = PTC_ACT_RESET;
        end else if (req_load_q) begin
            act = PTC_ACT_LOAD;
        end else if (req_step_q) begin
            act = PTC_ACT_STEP;
        end else if (run_q && tick) begin
            act = PTC_ACT_TICK;
        end else begin
            act = PTC_ACT_NONE;
        end
    end

    always_comb begin
        rtc_ns_d    = rtc_ns_q;
        rtc_sec_d   = rtc_sec_q;
        rtc_frac_d  = rtc_frac_q;
        rtc_phase_d = rtc_phase_q;
        case (act)
            PTC_ACT_RESET: begin
                rtc_ns_d    = 30'h0;
                rtc_sec_d   = 32'h0;
                rtc_frac_d  = 32'h0;
                rtc_phase_d = 3'b000;
            end
            PTC_ACT_LOAD: begin
                rtc_ns_d    = step_val;
                rtc_sec_d   = {sh_q, sl_q};
                rtc_frac_d  = 32'h0;
                rtc_phase_d = phase_q;
            end
            PTC_ACT_STEP: begin
                if (step_dir_q) begin
                    rtc_ns_d  = step_wr ? 30'(step_sum - {1'b0,
                                `PTC_NS_PER_SEC}) : step_sum[29:0];
                    rtc_sec_d = rtc_sec_q + {31'h0, step_wr};
                end else begin
                    rtc_ns_d  = step_un ? 30'(rtc_ns_q + `PTC_NS_PER_SEC
                                - step_val) : rtc_ns_q - step_val;
                    rtc_sec_d = rtc_sec_q - {31'h0, step_un};
                end
            end
            PTC_ACT_TICK: begin
                rtc_ns_d   = tick_wr ? adj_ns - `PTC_NS_PER_SEC : adj_ns;
                rtc_sec_d  = rtc_sec_q + {31'h0, tick_wr};
                rtc_frac_d = adj_fix[31:0];
            end
            default: begin
                rtc_ns_d = rtc_ns_q;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rtc_ns_q    <= 30'h0;
            rtc_sec_q   <= 32'h0;
            rtc_frac_q  <= 32'h0;
            rtc_phase_q <= 3'b000;
        end else begin
            rtc_ns_q    <= rtc_ns_d;
            rtc_sec_q   <= rtc_sec_d;
            rtc_frac_q  <= rtc_frac_d;
            rtc_phase_q <= rtc_phase_d;
        end
    end

    // ======================================================================
    // Control and self-clearing requests
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q      <= `PTC_RUN_RESET;
            cont_q     <= 1'b0;
            step_dir_q <= 1'b0;
            req_rst_q  <= 1'b0;
            req_load_q <= 1'b0;
            req_read_q <= 1'b0;
            req_step_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                run_q      <= host_wdata[`PTC_BIT_RUN];
                cont_q     <= host_wdata[`PTC_BIT_CONT];
                step_dir_q <= host_wdata[`PTC_BIT_STEPDIR];
            end
            req_rst_q  <= wr_ctrl && host_wdata[`PTC_BIT_RESET];
            req_load_q <= wr_ctrl && host_wdata[`PTC_BIT_LOAD];
            req_read_q <= wr_ctrl && host_wdata[`PTC_BIT_READ];
            req_step_q <= wr_ctrl && host_wdata[`PTC_BIT_STEP];
        end
    end

    // A host write that starts an adjustment wins over the expiry.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rate_l_q   <= `PTC_WORD_RESET;
            rate_h_q   <= 14'h0;
            rate_dir_q <= 1'b0;
            temp_q     <= 1'b0;
            dur_l_q    <= `PTC_WORD_RESET;
            dur_h_q    <= `PTC_WORD_RESET;
            dur_cnt_q  <= 32'h0;
        end else begin
            if (wr_ratel) rate_l_q <= host_wdata;
            if (wr_durl) dur_l_q <= host_wdata;
            if (wr_durh) dur_h_q <= host_wdata;
            if (wr_rateh) begin
                rate_h_q   <= host_wdata[13:0];
                rate_dir_q <= host_wdata[`PTC_BIT_RATEDIR];
                temp_q     <= host_wdata[`PTC_BIT_TEMP];
                dur_cnt_q  <= {dur_h_q, dur_l_q};
            end else begin
                if (temp_q && dur_done) temp_q <= 1'b0;
                if (temp_q && (act == PTC_ACT_TICK))
                    dur_cnt_q <= dur_cnt_q - 32'h1;
            end
        end
    end

    // ======================================================================
    // Time registers: host writes win over a snapshot in the same cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nsl_q   <= `PTC_WORD_RESET;
            nsh_q   <= `PTC_WORD_RESET;
            sl_q    <= `PTC_WORD_RESET;
            sh_q    <= `PTC_WORD_RESET;
            phase_q <= 3'b000;
        end else begin
            if (wr_nsl) nsl_q <= host_wdata;
            else if (req_read_q) nsl_q <= rtc_ns_q[15:0];
            if (wr_nsh) nsh_q <= host_wdata;
            else if (req_read_q) nsh_q <= {nsh_q[15:14], rtc_ns_q[29:16]};
            if (wr_sl) sl_q <= host_wdata;
            else if (req_read_q) sl_q <= rtc_sec_q[15:0];
            if (wr_sh) sh_q <= host_wdata;
            else if (req_read_q) sh_q <= rtc_sec_q[31:16];
            if (wr_phase) phase_q <= host_wdata[2:0];
            else if (wr_time) phase_q <= 3'b000;
            else if (req_read_q) phase_q <= rtc_phase_q;
        end
    end

    // ======================================================================
    // Read path: one cycle latency, unmapped offsets read zero.
    always_comb begin
        if (host_addr == `PTC_OFS_CTRL) begin
            rd_mux = {13'h0, cont_q, run_q, 1'b0}
                   | (16'(step_dir_q) << `PTC_BIT_STEPDIR);
        end else if (host_addr == `PTC_OFS_NSL) begin
            rd_mux = nsl_q;
        end else if (host_addr == `PTC_OFS_NSH) begin
            rd_mux = nsh_q;
        end else if (host_addr == `PTC_OFS_SL) begin
            rd_mux = sl_q;
        end else if (host_addr == `PTC_OFS_SH) begin
            rd_mux = sh_q;
        end else if (host_addr == `PTC_OFS_PHASE) begin
            rd_mux = {13'h0, phase_q};
        end else if (host_addr == `PTC_OFS_RATEL) begin
            rd_mux = rate_l_q;
        end else if (host_addr == `PTC_OFS_RATEH) begin
            rd_mux = {rate_dir_q, temp_q, rate_h_q};
        end else if (host_addr == `PTC_OFS_DURL) begin
            rd_mux = dur_l_q;
        end else if (host_addr == `PTC_OFS_DURH) begin
            rd_mux = dur_h_q;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) host_rdata_q <= 16'h0000;
        else if (host_rd) host_rdata_q <= rd_mux;
    end

    // ======================================================================
    // Assertions
    default clocking ck @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence plain_tick;
        act == PTC_ACT_TICK && !rate_on && !tick_wr;
    endsequence
    sequence rate_up_tick;
        act == PTC_ACT_TICK && rate_on && !rate_dir_q && !tick_wr;
    endsequence

    frozen_hold_a: assert property (
        act == PTC_ACT_NONE |=> $stable(rtc_ns_q) && $stable(rtc_sec_q))
        else $error("Time moved while frozen.");
    tick_adv_a: assert property (
        plain_tick |=> rtc_ns_q == $past(rtc_ns_q) + 30'd40
                       && $stable(rtc_frac_q))
        else $error("Tick did not add the reference period.");
    rate_up_a: assert property (
        rate_up_tick |=> {rtc_ns_q, rtc_frac_q} == $past(cur_fix)
            + {30'd40, 32'h0} + $past(rate_fix))
        else $error("Rate not added on tick.");
    rate_zero_a: assert property (
        act == PTC_ACT_TICK && rate_val == 32'h0 |=> $stable(rtc_frac_q))
        else $error("Zero rate still adjusted.");
    ns_wrap_a: assert property (
        rtc_ns_q < `PTC_NS_PER_SEC)
        else $error("Nanoseconds reached one second.");
    reset_req_a: assert property (
        wr_ctrl && host_wdata[0] |=> ##1 rtc_ns_q == 30'h0
            && rtc_sec_q == 32'h0 && !req_rst_q)
        else $error("Clock reset request failed.");
    phase_zero_a: assert property (
        wr_time |=> phase_q == 3'b000)
        else $error("Sub-phase not zeroed by time write.");
    load_time_a: assert property (
        req_load_q |=> rtc_sec_q == $past({sh_q, sl_q})
            && rtc_ns_q == $past(step_val))
        else $error("Load did not copy the time registers.");
    snapshot_a: assert property (
        req_read_q && !host_wr |=> {sh_q, sl_q} == $past(rtc_sec_q)
            && nsl_q == $past(rtc_ns_q[15:0]))
        else $error("Snapshot did not capture live time.");
    step_add_a: assert property (
        act == PTC_ACT_STEP && step_dir_q && !step_wr
            |=> rtc_ns_q == $past(step_sum[29:0]))
        else $error("Step add gave a wrong value.");
    temp_end_a: assert property (
        temp_q && !wr_rateh && act == PTC_ACT_TICK && dur_cnt_q == 32'h1
            |=> !temp_q)
        else $error("Temporary adjust did not end.");
endmodule : ptc_core

/* File: ptp_time_clock_core_tb.sv */
// Self-checking testbench for the time clock core register interface.
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptp_time_clock_core_tb;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [11:0] host_addr = 12'h000;
    logic        host_wr = 1'b0;
    logic        host_rd = 1'b0;
    logic [15:0] host_wdata = 16'h0000;
    wire  [15:0] host_rdata_q;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc = 0;
    logic [15:0] ctl = 16'h0002;

    always #10 clk = ~clk;

    ptc_core u_ptc_core (
        .clk          (clk),
        .reset_n      (reset_n),
        .host_addr    (host_addr),
        .host_wr      (host_wr),
        .host_rd      (host_rd),
        .host_wdata   (host_wdata),
        .host_rdata_q (host_rdata_q)
    );

    // ======================================================================
    // Closing report and hang guard
    task automatic print_verdict();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cyc++;
        if (cyc >= 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ======================================================================
    // Bus cycles and comparison
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Strobes stay up after a transfer and the next task or idle lowers
    // them, so no strobe is driven twice in one time step.
    task automatic idle(input int n);
        host_wr = 1'b0;
        host_rd = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        host_addr  = a;
        host_wdata = d;
        host_rd    = 1'b0;
        host_wr    = 1'b1;
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        host_addr = a;
        host_wr   = 1'b0;
        host_rd   = 1'b1;
        @(posedge clk);
        #1;
        d         = host_rdata_q;
    endtask : rd

    task automatic rdchk(input logic [11:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk({48'h0, d}, {48'h0, exp});
    endtask : rdchk

    // The snapshot takes exactly seven edges, so stamps differ by the wait plus seven.
    task automatic snap(output logic [31:0] s, output logic [29:0] n,
                        output int st);
        logic [15:0] w0, w1, w2, w3;
        wr(`PTC_OFS_CTRL, ctl | 16'h0010);
        st = cyc;
        idle(2);
        rd(`PTC_OFS_NSL, w0);
        rd(`PTC_OFS_NSH, w1);
        rd(`PTC_OFS_SL, w2);
        rd(`PTC_OFS_SH, w3);
        n = {w1[13:0], w0};
        s = {w3, w2};
    endtask : snap

    function automatic logic [63:0] tot(input logic [31:0] s,
                                        input logic [29:0] n);
        return {32'h0, s} * {34'h0, `PTC_NS_PER_SEC} + {34'h0, n};
    endfunction : tot

    // Wait w is chosen so that the two snapshot edges are an even count
    // apart; dl is then compared against 20 ns per clock of separation.
    task automatic meas(input int w, output logic [63:0] dl,
                        output logic [31:0] sb, output logic [29:0] nb);
        logic [31:0] sa;
        logic [29:0] na;
        int          ta, tb;
        snap(sa, na, ta);
        idle(w);
        snap(sb, nb, tb);
        dl = tot(sb, nb) - tot(sa, na);
        chk(tb - ta, w + 7);
    endtask : meas

    // ======================================================================
    // Scenarios
    task automatic t_reset_values();
        logic [11:0] a [8] = '{`PTC_OFS_CTRL, `PTC_OFS_NSL, `PTC_OFS_NSH,
            `PTC_OFS_SL, `PTC_OFS_SH, `PTC_OFS_PHASE, `PTC_OFS_RATEL,
            12'h602};
        for (int i = 0; i < 8; i++) begin
            rdchk(a[i], (i == 0) ? 16'h0002 : 16'h0000);
        end
    endtask : t_reset_values

    task automatic t_rw();
        logic [11:0] a [5] = '{`PTC_OFS_NSL, `PTC_OFS_NSH, `PTC_OFS_SL,
            `PTC_OFS_SH, `PTC_OFS_RATEL};
        logic [15:0] d [5] = '{16'hA5C3, 16'hFFFF, 16'h1234, 16'hFEDC,
            16'h8001};
        for (int i = 0; i < 5; i++) begin
            wr(a[i], d[i]);
        end
        for (int i = 0; i < 5; i++) begin
            rdchk(a[i], d[i]);
        end
        wr(12'h602, 16'hFFFF);
        rdchk(12'h602, 16'h0000);
    endtask : t_rw

    task automatic t_phase();
        logic [11:0] a [4] = '{`PTC_OFS_NSL, `PTC_OFS_NSH, `PTC_OFS_SL,
            `PTC_OFS_SH};
        for (int i = 0; i < 5; i++) begin
            wr(`PTC_OFS_PHASE, i[15:0]);
            rdchk(`PTC_OFS_PHASE, i[15:0]);
            wr(a[i % 4], 16'h0000);
            rdchk(`PTC_OFS_PHASE, 16'h0000);
        end
    endtask : t_phase

    task automatic t_reset_freeze();
        logic [63:0] dl;
        logic [31:0] s;
        logic [29:0] n;
        int          st;
        ctl = 16'h0000;
        wr(`PTC_OFS_CTRL, 16'h0001);
        rdchk(`PTC_OFS_CTRL, 16'h0000);
        snap(s, n, st);
        chk(tot(s, n), 64'h0);
        rdchk(`PTC_OFS_CTRL, 16'h0000);
        meas(793, dl, s, n);
        chk(dl, 64'h0);
    endtask : t_reset_freeze

    task automatic t_load_wrap();
        logic [63:0] dl;
        logic [31:0] s;
        logic [29:0] n;
        int          st;
        wr(`PTC_OFS_NSL, 16'hC870);
        wr(`PTC_OFS_NSH, 16'hFB9A);
        wr(`PTC_OFS_SL, 16'h0005);
        wr(`PTC_OFS_SH, 16'h0000);
        wr(`PTC_OFS_CTRL, 16'h0008);
        rdchk(`PTC_OFS_CTRL, 16'h0000);
        snap(s, n, st);
        chk({s, 2'b00, n}, {32'h5, 32'h3B9AC870});
        rdchk(`PTC_OFS_NSH, 16'hFB9A);
        ctl = 16'h0002;
        wr(`PTC_OFS_CTRL, ctl);
        meas(33, dl, s, n);
        chk({32'h0, s}, 64'h6);
        chk({63'h0, n < `PTC_NS_PER_SEC}, 64'h1);
        chk(dl, 64'd800);
    endtask : t_load_wrap

    task automatic t_rate();
        logic [63:0] dl;
        logic [31:0] s;
        logic [29:0] n;
        wr(`PTC_OFS_RATEL, 16'hFFFF);
        wr(`PTC_OFS_RATEH, 16'h3FFF);
        meas(793, dl, s, n);
        chk(dl, 64'd16000);
        ctl = 16'h0006;
        wr(`PTC_OFS_CTRL, ctl);
        meas(793, dl, s, n);
        chk({63'h0, dl inside {64'd16099, 64'd16100}}, 64'h1);
        wr(`PTC_OFS_RATEH, 16'hBFFF);
        meas(793, dl, s, n);
        chk({63'h0, dl inside {64'd15900, 64'd15901}}, 64'h1);
        wr(`PTC_OFS_RATEL, 16'h0000);
        wr(`PTC_OFS_RATEH, 16'h8000);
        meas(793, dl, s, n);
        chk(dl, 64'd16000);
    endtask : t_rate

    task automatic t_temp();
        wr(`PTC_OFS_DURL, 16'h0064);
        wr(`PTC_OFS_DURH, 16'h0000);
        wr(`PTC_OFS_RATEL, 16'hFFFF);
        wr(`PTC_OFS_RATEH, 16'h7FFF);
        rdchk(`PTC_OFS_RATEH, 16'h7FFF);
        // At most 96 of the 100 counted ticks have passed here.
        idle(190);
        rdchk(`PTC_OFS_RATEH, 16'h7FFF);
        idle(8);
        rdchk(`PTC_OFS_RATEH, 16'h3FFF);
    endtask : t_temp

    task automatic t_step();
        logic [31:0] s;
        logic [29:0] n;
        int          st;
        ctl = 16'h0000;
        wr(`PTC_OFS_CTRL, 16'h0001);
        wr(`PTC_OFS_NSL, 16'h1388);
        wr(`PTC_OFS_NSH, 16'h0000);
        wr(`PTC_OFS_CTRL, 16'h0060);
        idle(3);
        snap(s, n, st);
        chk(tot(s, n), 64'd5000);
        wr(`PTC_OFS_NSL, 16'h012C);
        wr(`PTC_OFS_NSH, 16'h0000);
        wr(`PTC_OFS_CTRL, 16'h0040);
        idle(3);
        snap(s, n, st);
        chk(tot(s, n), 64'd4700);
        rdchk(`PTC_OFS_CTRL, 16'h0000);
    endtask : t_step

    // ======================================================================
    // Main sequence
    initial begin
        idle(6);
        reset_n = 1'b1;
        t_reset_values();
        t_rw();
        t_phase();
        t_reset_freeze();
        t_load_wrap();
        t_rate();
        t_temp();
        t_step();
        print_verdict();
    end
endmodule : ptp_time_clock_core_tb
